// ==== verilog/sosb_bank.sv ====
// system option select bank with wishbone slave and signal routing
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sosb_consts.svh"
module sosb_bank #(
  parameter int ADR_W = 13,
  parameter sosb_pkg::sosb_word_t IDENT_VALUE = 32'h0000_0000 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_lvd_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire sosb_pkg::sosb_word_t wb_dat_i,
  output sosb_pkg::sosb_word_t wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic supervisor_i,
  input wire logic sys_osc_32k_clock_i,
  input wire logic rtc_clock_in_pin_i,
  input wire logic low_power_osc_i,
  input wire logic fll_output_clock_i,
  input wire logic osc_ext_ref_clock_i,
  input wire logic internal_ref_clock_i,
  input wire logic rtc_1hz_i,
  input wire logic timer_clock_in_pin0_i,
  input wire logic timer_clock_in_pin1_i,
  input wire logic comparator_zero_i,
  input wire logic timer1_ch0_pin_i,
  input wire logic timer2_ch0_pin_i,
  input wire logic serial0_rx_pin_i,
  input wire logic serial1_rx_pin_i,
  input wire logic serial0_tx_data_i,
  input wire logic serial1_tx_data_i,
  input wire logic timer1_ch0_out_i,
  input wire logic timer2_ch0_out_i,
  input wire logic timer1_ch1_out_i,
  input wire logic external_trigger_pin_i,
  input wire logic periodic_trigger0_i,
  input wire logic periodic_trigger1_i,
  input wire logic timer0_overflow_i,
  input wire logic timer1_overflow_i,
  input wire logic timer2_overflow_i,
  input wire logic rtc_alarm_i,
  input wire logic rtc_seconds_i,
  input wire logic low_power_timer_trigger_i,
  output logic ref32k_clock_o,
  output logic serial0_clock_o,
  output logic timer_pwm_clock_o,
  output logic clock_output_pin_o,
  output logic rtc_output_pin_o,
  output logic [2:0] timer_ext_clock_o,
  output logic timer1_capture_o,
  output logic timer2_capture_o,
  output logic [2:0] serial_open_drain_enable_o,
  output logic serial0_rx_o,
  output logic serial1_rx_o,
  output logic serial0_tx_pin_o,
  output logic serial1_tx_pin_o,
  output logic converter_trigger_o,
  output logic converter_pretrigger_b_o
);
  import sosb_pkg::*;
  default disable iff (rst_i || por_lvd_rst_i);
  localparam logic [7:0] CLOCK_OUTPUT_PIN_LEGAL = `SOSB_CLOCK_OUTPUT_PIN_LEGAL;

  if (ADR_W < `SOSB_ADR_MIN) begin : g_bad_adr
    $error("sosb_bank: ADR_W too small for the register map");
  end

  sosb_bus_state_t state;
  sosb_word_t ref32k_reg;
  sosb_word_t modclk_reg;
  sosb_word_t timer_reg;
  sosb_word_t serial_reg;
  sosb_word_t conv_reg;
  sosb_word_t next_rdata;
  sosb_word_t lane_mask;
  logic [`SOSB_SYNC_W-1:0] sync_q;
  logic hit;
  logic ok;
  logic wr_now;
  logic bus_div;
  logic [`SOSB_ADR_MIN-1:0] adr;
  logic s_sysosc, s_rtcpin, s_lpo, s_fll, s_oscref, s_irc, s_rtc1hz, s_tclk0, s_tclk1;
  logic s_comparator_zero, s_t1pin, s_t2pin, s_rx0, s_rx1, s_tx0, s_tx1, s_t1ch0, s_t2ch0, s_t1ch1;
  logic s_ext, s_pit0, s_pit1, s_ovf0, s_ovf1, s_ovf2, s_alarm, s_sec, s_low_power_timer;
  logic p_ref32k, p_s0clk, p_tpmclk, p_clock_output_pin, p_rtcout, p_tx0, p_tx1, p_trg;
  logic [2:0] p_tclk;

  assign adr = wb_adr_i[`SOSB_ADR_MIN-1:0];
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // address decode and read mux
  always_comb begin
    hit = 1'b1;
    next_rdata = `SOSB_RESET_WORD;
    case (adr)
      `SOSB_OFF_REF32K: next_rdata = ref32k_reg & `SOSB_REF32K_MASK;
      `SOSB_OFF_CFG: next_rdata = `SOSB_RESET_WORD;
      `SOSB_OFF_MODCLK: next_rdata = modclk_reg & `SOSB_MODCLK_MASK;
      `SOSB_OFF_TIMER: next_rdata = timer_reg & `SOSB_TIMER_MASK;
      `SOSB_OFF_SERIAL: next_rdata = serial_reg & `SOSB_SERIAL_MASK;
      `SOSB_OFF_CONV: next_rdata = conv_reg & `SOSB_CONV_MASK;
      `SOSB_OFF_IDENT: next_rdata = IDENT_VALUE;
      default: hit = 1'b0;
    endcase
    if (wb_adr_i[ADR_W-1:0] != ADR_W'(adr)) begin
      hit = 1'b0;
    end
  end

  // user-mode writes refused with an error
  assign ok = hit && !(wb_we_i && !supervisor_i);
  // write lands on the edge that the master samples ack
  assign wr_now = !rst_i && !por_lvd_rst_i && state == SOSB_ANSWER && wb_ack_o && wb_we_i
                  && wb_cyc_i && wb_stb_i;

  // bus answer: one-cycle ack or err
  always_ff @(posedge clk_i) begin
    if (rst_i || por_lvd_rst_i) begin
      state <= SOSB_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= `SOSB_RESET_WORD;
    end else begin
      case (state)
        SOSB_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            state <= SOSB_ANSWER;
            wb_ack_o <= ok;
            wb_err_o <= !ok;
            wb_dat_o <= wb_we_i ? `SOSB_RESET_WORD : next_rdata;
          end
        end
        SOSB_ANSWER: begin
          state <= SOSB_IDLE;
          wb_ack_o <= 1'b0;
          wb_err_o <= 1'b0;
        end
        default: state <= SOSB_IDLE;
      endcase
    end
  end

  // 32k select held through system reset
  always_ff @(posedge clk_i) begin
    if (por_lvd_rst_i) begin
      ref32k_reg <= `SOSB_RESET_WORD;
    end else if (wr_now && adr == `SOSB_OFF_REF32K) begin
      ref32k_reg <= (ref32k_reg & ~(lane_mask & `SOSB_REF32K_MASK))
                    | (wb_dat_i & lane_mask & `SOSB_REF32K_MASK);
    end
  end

  // remaining option registers
  always_ff @(posedge clk_i) begin
    if (rst_i || por_lvd_rst_i) begin
      modclk_reg <= `SOSB_RESET_WORD;
      timer_reg <= `SOSB_RESET_WORD;
      serial_reg <= `SOSB_RESET_WORD;
      conv_reg <= `SOSB_RESET_WORD;
    end else if (wr_now) begin
      if (adr == `SOSB_OFF_MODCLK) begin
        modclk_reg <= (modclk_reg & ~(lane_mask & `SOSB_MODCLK_MASK))
                      | (wb_dat_i & lane_mask & `SOSB_MODCLK_MASK);
      end
      if (adr == `SOSB_OFF_TIMER) begin
        timer_reg <= (timer_reg & ~(lane_mask & `SOSB_TIMER_MASK))
                     | (wb_dat_i & lane_mask & `SOSB_TIMER_MASK);
      end
      if (adr == `SOSB_OFF_SERIAL) begin
        serial_reg <= (serial_reg & ~(lane_mask & `SOSB_SERIAL_MASK))
                      | (wb_dat_i & lane_mask & `SOSB_SERIAL_MASK);
      end
      if (adr == `SOSB_OFF_CONV) begin
        conv_reg <= (conv_reg & ~(lane_mask & `SOSB_CONV_MASK))
                    | (wb_dat_i & lane_mask & `SOSB_CONV_MASK);
      end
    end
  end

  // bus clock stand-in at half rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_div <= 1'b0;
    end else begin
      bus_div <= !bus_div;
    end
  end

  sosb_sync #(.WIDTH(`SOSB_SYNC_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({sys_osc_32k_clock_i, rtc_clock_in_pin_i, low_power_osc_i, fll_output_clock_i,
              osc_ext_ref_clock_i, internal_ref_clock_i, rtc_1hz_i, timer_clock_in_pin0_i,
              timer_clock_in_pin1_i, comparator_zero_i, timer1_ch0_pin_i, timer2_ch0_pin_i,
              serial0_rx_pin_i, serial1_rx_pin_i, serial0_tx_data_i, serial1_tx_data_i,
              timer1_ch0_out_i, timer2_ch0_out_i, timer1_ch1_out_i, external_trigger_pin_i,
              periodic_trigger0_i, periodic_trigger1_i, timer0_overflow_i, timer1_overflow_i,
              timer2_overflow_i, rtc_alarm_i, rtc_seconds_i, low_power_timer_trigger_i}),
    .sync_o(sync_q)
  );
  assign {s_sysosc, s_rtcpin, s_lpo, s_fll, s_oscref, s_irc, s_rtc1hz, s_tclk0, s_tclk1,
          s_comparator_zero, s_t1pin, s_t2pin, s_rx0, s_rx1, s_tx0, s_tx1, s_t1ch0, s_t2ch0, s_t1ch1,
          s_ext, s_pit0, s_pit1, s_ovf0, s_ovf1, s_ovf2, s_alarm, s_sec, s_low_power_timer} = sync_q;

  // selectors read the stored fields directly
  sosb_pick #(.SELW(2)) u_ref32k (
    .src_i({s_lpo, s_rtcpin, 1'b0, s_sysosc}),
    .legal_i(`SOSB_REF32K_LEGAL),
    .sel_i(ref32k_reg[`SOSB_REF32K_MSB:`SOSB_REF32K_LSB]),
    .pick_o(p_ref32k)
  );
  sosb_pick #(.SELW(2)) u_s0clk (
    .src_i({s_irc, s_oscref, s_fll, 1'b0}),
    .legal_i(`SOSB_MODCLK_LEGAL),
    .sel_i(modclk_reg[`SOSB_S0CLK_MSB:`SOSB_S0CLK_LSB]),
    .pick_o(p_s0clk)
  );
  sosb_pick #(.SELW(2)) u_tpmclk (
    .src_i({s_irc, s_oscref, s_fll, 1'b0}),
    .legal_i(`SOSB_MODCLK_LEGAL),
    .sel_i(modclk_reg[`SOSB_TPMCLK_MSB:`SOSB_TPMCLK_LSB]),
    .pick_o(p_tpmclk)
  );
  sosb_pick #(.SELW(3)) u_clock_output_pin (
    .src_i({1'b0, s_oscref, 1'b0, s_irc, s_lpo, bus_div, 1'b0, 1'b0}),
    .legal_i(`SOSB_CLOCK_OUTPUT_PIN_LEGAL),
    .sel_i(modclk_reg[`SOSB_CLOCK_OUTPUT_PIN_MSB:`SOSB_CLOCK_OUTPUT_PIN_LSB]),
    .pick_o(p_clock_output_pin)
  );
  sosb_pick #(.SELW(1)) u_rtcout (
    .src_i({s_oscref, s_rtc1hz}),
    .legal_i(`SOSB_ONE_BIT_LEGAL),
    .sel_i(modclk_reg[`SOSB_RTCOUT_BIT]),
    .pick_o(p_rtcout)
  );
  // pin function setup for the clock-in pins is the port logic's job
  for (genvar i = 0; i < 3; i++) begin : g_tclk
    sosb_pick #(.SELW(1)) u_tclk (
      .src_i({s_tclk1, s_tclk0}),
      .legal_i(`SOSB_ONE_BIT_LEGAL),
      .sel_i(timer_reg[`SOSB_T0CLK_BIT + i]),
      .pick_o(p_tclk[i])
    );
  end
  sosb_pick #(.SELW(2)) u_tx0 (
    .src_i({1'b0, s_tx0 & s_t2ch0, s_tx0 & s_t1ch0, s_tx0}),
    .legal_i(`SOSB_TX_LEGAL),
    .sel_i(serial_reg[`SOSB_TX0_MSB:`SOSB_TX0_LSB]),
    .pick_o(p_tx0)
  );
  sosb_pick #(.SELW(2)) u_tx1 (
    .src_i({1'b0, s_tx1 & s_t2ch0, s_tx1 & s_t1ch0, s_tx1}),
    .legal_i(`SOSB_TX_LEGAL),
    .sel_i(serial_reg[`SOSB_TX1_MSB:`SOSB_TX1_LSB]),
    .pick_o(p_tx1)
  );
  sosb_pick #(.SELW(4)) u_trg (
    .src_i({1'b0, s_low_power_timer, s_sec, s_alarm, 1'b0, s_ovf2, s_ovf1, s_ovf0,
            1'b0, 1'b0, s_pit1, s_pit0, 1'b0, 1'b0, s_comparator_zero, s_ext}),
    .legal_i(`SOSB_TRG_LEGAL),
    .sel_i(conv_reg[`SOSB_TRG_MSB:`SOSB_TRG_LSB]),
    .pick_o(p_trg)
  );

  assign serial_open_drain_enable_o = serial_reg[`SOSB_ODE_MSB:`SOSB_ODE_LSB];

  // registered routed outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref32k_clock_o <= 1'b0;
      serial0_clock_o <= 1'b0;
      timer_pwm_clock_o <= 1'b0;
      clock_output_pin_o <= 1'b0;
      rtc_output_pin_o <= 1'b0;
      timer_ext_clock_o <= '0;
      timer1_capture_o <= 1'b0;
      timer2_capture_o <= 1'b0;
      serial0_rx_o <= 1'b0;
      serial1_rx_o <= 1'b0;
      serial0_tx_pin_o <= 1'b0;
      serial1_tx_pin_o <= 1'b0;
      converter_trigger_o <= 1'b0;
      converter_pretrigger_b_o <= 1'b0;
    end else begin
      ref32k_clock_o <= p_ref32k;
      serial0_clock_o <= p_s0clk;
      timer_pwm_clock_o <= p_tpmclk;
      clock_output_pin_o <= p_clock_output_pin;
      rtc_output_pin_o <= p_rtcout;
      timer_ext_clock_o <= p_tclk;
      // capture source; software clears it outside capture mode
      timer1_capture_o <= timer_reg[`SOSB_T1CAP_BIT] ? s_comparator_zero : s_t1pin;
      timer2_capture_o <= timer_reg[`SOSB_T2CAP_BIT] ? s_comparator_zero : s_t2pin;
      serial0_rx_o <= serial_reg[`SOSB_RX0_BIT] ? s_comparator_zero : s_rx0;
      serial1_rx_o <= serial_reg[`SOSB_RX1_BIT] ? s_comparator_zero : s_rx1;
      serial0_tx_pin_o <= p_tx0;
      serial1_tx_pin_o <= p_tx1;
      converter_trigger_o <= conv_reg[`SOSB_ALT_BIT] ? p_trg : (s_t1ch0 | s_t1ch1);
      converter_pretrigger_b_o <= conv_reg[`SOSB_ALT_BIT] ? conv_reg[`SOSB_PRETRG_BIT]
                                  : s_t1ch1;
    end
  end

  // checks
  AST_USER_WRITE_ERR: assert property (@(posedge clk_i)
    state == SOSB_IDLE && wb_cyc_i && wb_stb_i && wb_we_i && !supervisor_i
    |=> wb_err_o && !wb_ack_o)
    else $error("user write not refused");
  AST_USER_WRITE_BLOCKED: assert property (@(posedge clk_i)
    wb_err_o |=> $stable(modclk_reg) && $stable(timer_reg) && $stable(serial_reg)
    && $stable(conv_reg) && $stable(ref32k_reg))
    else $error("refused access changed a register");
  AST_ANSWER_ONE_CYCLE: assert property (@(posedge clk_i)
    state == SOSB_IDLE && wb_cyc_i && wb_stb_i
    |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o))
    else $error("bus answer not one cycle");
  AST_WRITE_TAKES: assert property (@(posedge clk_i)
    wr_now && adr == `SOSB_OFF_TIMER && wb_sel_i == 4'hF
    |=> timer_reg == ($past(wb_dat_i) & `SOSB_TIMER_MASK))
    else $error("write not stored");
  AST_REF32K_KEEP: assert property (@(posedge clk_i) disable iff (por_lvd_rst_i)
    rst_i |=> $stable(ref32k_reg))
    else $error("32k select lost on system reset");
  AST_CFG_ZERO: assert property (@(posedge clk_i)
    wb_ack_o && !wb_we_i && adr == `SOSB_OFF_CFG |-> wb_dat_o == `SOSB_RESET_WORD)
    else $error("config register not zero");
  AST_RSVD_ZERO: assert property (@(posedge clk_i)
    wb_ack_o && !wb_we_i && adr == `SOSB_OFF_CONV
    |-> (wb_dat_o & ~`SOSB_CONV_MASK) == `SOSB_RESET_WORD)
    else $error("reserved bits read nonzero");
  AST_S0CLK_OFF: assert property (@(posedge clk_i)
    modclk_reg[`SOSB_S0CLK_MSB:`SOSB_S0CLK_LSB] == 2'h0 |=> !serial0_clock_o)
    else $error("serial0 clock not gated");
  AST_TPMCLK_FLL: assert property (@(posedge clk_i)
    modclk_reg[`SOSB_TPMCLK_MSB:`SOSB_TPMCLK_LSB] == 2'h1 |=> timer_pwm_clock_o == $past(s_fll))
    else $error("timer clock not fll");
  AST_CLOCK_OUTPUT_PIN_RSVD: assert property (@(posedge clk_i)
    !CLOCK_OUTPUT_PIN_LEGAL[modclk_reg[`SOSB_CLOCK_OUTPUT_PIN_MSB:`SOSB_CLOCK_OUTPUT_PIN_LSB]] |=> !clock_output_pin_o)
    else $error("reserved clock output code drives pin");
  AST_TX_PLAIN: assert property (@(posedge clk_i)
    serial_reg[`SOSB_TX0_MSB:`SOSB_TX0_LSB] == 2'h0 |=> serial0_tx_pin_o == $past(s_tx0))
    else $error("plain transmit wrong");
  AST_ALT_OFF: assert property (@(posedge clk_i)
    !conv_reg[`SOSB_ALT_BIT] |=> converter_trigger_o == ($past(s_t1ch0) | $past(s_t1ch1)))
    else $error("default trigger wrong");
  AST_TRG_PIT0: assert property (@(posedge clk_i)
    conv_reg[`SOSB_ALT_BIT] && conv_reg[`SOSB_TRG_MSB:`SOSB_TRG_LSB] == 4'h4
    |=> converter_trigger_o == $past(s_pit0))
    else $error("alternate trigger wrong");
endmodule : sosb_bank
`default_nettype wire

// ==== verilog/sosb_consts.svh ====
// constants for the system option select bank
// How it works
// - 32k reference select: 00 system osc, 10 clock-in pin, 11 1 kHz osc.
// - 32k reference select resets only on power-on or low-voltage reset.
// - option one config register is reset by system reset only, reads zero.
// - reserved bits are read-only and always read zero.
// - serial0 clock source: 00 off, 01 FLL, 10 osc ext ref, 11 internal ref.
// - timer/PWM clock source uses the same four codes as serial0.
// - clock output: 010 bus, 011 1 kHz osc, 100 internal ref, 110 osc ref.
// - rtc output pin: 0 gives 1 Hz rtc clock, 1 gives osc ext ref.
// - timer external clock pin select: 0 clock-in pin 0, 1 clock-in pin 1.
// - channel 0 capture source: 0 channel pin, 1 comparator zero output.
// - open-drain enable per serial port, 1 enables.
// - serial receive source: 0 receive pin, 1 comparator zero output.
// - serial transmit: 00 plain, 01 with timer1 ch0, 10 with timer2 ch0.
// - converter alt trigger enable: 0 timer1 ch0/ch1, 1 alternate source.
// - with alt triggers, pretrigger select 0 gives A, 1 gives B.
// - converter trigger select picks one of the listed sources.
// - writes only in supervisor mode; user writes give a bus error.
`ifndef SOSB_CONSTS_SVH
`define SOSB_CONSTS_SVH
`define SOSB_ADR_MIN 13
`define SOSB_OFF_REF32K 13'h0000
`define SOSB_OFF_CFG 13'h0004
`define SOSB_OFF_MODCLK 13'h1004
`define SOSB_OFF_TIMER 13'h100C
`define SOSB_OFF_SERIAL 13'h1010
`define SOSB_OFF_CONV 13'h1018
`define SOSB_OFF_IDENT 13'h1024
`define SOSB_REF32K_MASK 32'h000C_0000
`define SOSB_MODCLK_MASK 32'h0F00_00F0
`define SOSB_TIMER_MASK 32'h0714_0000
`define SOSB_SERIAL_MASK 32'h0007_0077
`define SOSB_CONV_MASK 32'h0000_009F
`define SOSB_RESET_WORD 32'h0000_0000
`define SOSB_REF32K_MSB 19
`define SOSB_REF32K_LSB 18
`define SOSB_S0CLK_MSB 27
`define SOSB_S0CLK_LSB 26
`define SOSB_TPMCLK_MSB 25
`define SOSB_TPMCLK_LSB 24
`define SOSB_CLOCK_OUTPUT_PIN_MSB 7
`define SOSB_CLOCK_OUTPUT_PIN_LSB 5
`define SOSB_RTCOUT_BIT 4
`define SOSB_T2CLK_BIT 26
`define SOSB_T1CLK_BIT 25
`define SOSB_T0CLK_BIT 24
`define SOSB_T2CAP_BIT 20
`define SOSB_T1CAP_BIT 18
`define SOSB_ODE_MSB 18
`define SOSB_ODE_LSB 16
`define SOSB_RX1_BIT 6
`define SOSB_TX1_MSB 5
`define SOSB_TX1_LSB 4
`define SOSB_RX0_BIT 2
`define SOSB_TX0_MSB 1
`define SOSB_TX0_LSB 0
`define SOSB_ALT_BIT 7
`define SOSB_PRETRG_BIT 4
`define SOSB_TRG_MSB 3
`define SOSB_TRG_LSB 0
`define SOSB_REF32K_LEGAL 4'hD
`define SOSB_MODCLK_LEGAL 4'hE
`define SOSB_CLOCK_OUTPUT_PIN_LEGAL 8'h5C
`define SOSB_TX_LEGAL 4'h7
`define SOSB_TRG_LEGAL 16'h7733
`define SOSB_ONE_BIT_LEGAL 2'h3
`define SOSB_SYNC_W 28
`endif

// ==== verilog/sosb_pkg.sv ====
// types of the system option select bank
package sosb_pkg;
  typedef logic [31:0] sosb_word_t;
  typedef enum logic {SOSB_IDLE, SOSB_ANSWER} sosb_bus_state_t;
endpackage : sosb_pkg

// ==== verilog/sosb_sync.sv ====
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sosb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  if (WIDTH < 1) begin : g_bad_width
    $error("sosb_sync: WIDTH must be at least 1");
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      // accept a bit once stages two and three agree
      sync_o <= (stage2 & stage3) | (sync_o & (stage2 ^ stage3));
    end
  end
endmodule : sosb_sync
`default_nettype wire

// ==== verilog/sosb_pick.sv ====
// code-indexed selector, reserved codes give zero
`timescale 1ns/1ps
`default_nettype none
module sosb_pick #(
  parameter int SELW = 2
) (
  input wire logic [(1<<SELW)-1:0] src_i,
  input wire logic [(1<<SELW)-1:0] legal_i,
  input wire logic [SELW-1:0] sel_i,
  output logic pick_o
);
  if (SELW < 1) begin : g_bad_selw
    $error("sosb_pick: SELW must be at least 1");
  end
  assign pick_o = legal_i[sel_i] & src_i[sel_i];
endmodule : sosb_pick
`default_nettype wire

// ==== tb/sosb_peer.sv ====
// stand-in for the peripherals that feed the bank's routing sources
`timescale 1ns/1ps
`default_nettype none
module sosb_peer (
  input wire logic [27:0] src_i,
  output logic [27:0] lvl_o
);
  // plain held levels; clock-in pins taken as set to clock function
  assign lvl_o = src_i;
endmodule : sosb_peer
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench of the system option select bank
`timescale 1ns/1ps
`default_nettype none
`include "sosb_consts.svh"
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_top import sosb_pkg::*;;
  localparam sosb_word_t IDV = 32'h0000_5A5A; // arbitrary value
  localparam int R32[4] = '{0, 31, 1, 2};
  localparam int C4[4] = '{31, 3, 4, 5};
  localparam int CO[8] = '{31, 31, 31, 2, 5, 31, 4, 31};
  localparam int TG[16] = '{19, 9, 31, 31, 20, 21, 31, 31, 22, 23, 24, 31, 25, 26, 27, 31};
  localparam logic [12:0] OFS[5] = '{`SOSB_OFF_REF32K, `SOSB_OFF_MODCLK, `SOSB_OFF_TIMER,
    `SOSB_OFF_SERIAL, `SOSB_OFF_CONV};
  localparam sosb_word_t MSK[5] = '{`SOSB_REF32K_MASK, `SOSB_MODCLK_MASK, `SOSB_TIMER_MASK,
    `SOSB_SERIAL_MASK, `SOSB_CONV_MASK};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_lvd_rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic supervisor_i = 1'b1;
  logic [12:0] wb_adr_i = 13'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  sosb_word_t wb_dat_i = 32'h0000_0000;
  sosb_word_t wb_dat_o;
  logic wb_ack_o, wb_err_o, ref32k_clock_o, serial0_clock_o, timer_pwm_clock_o;
  logic clock_output_pin_o, rtc_output_pin_o, timer1_capture_o, timer2_capture_o;
  logic serial0_rx_o, serial1_rx_o, serial0_tx_pin_o, serial1_tx_pin_o;
  logic converter_trigger_o, converter_pretrigger_b_o;
  logic [2:0] timer_ext_clock_o, serial_open_drain_enable_o;
  logic [27:0] src = 28'h0000000;
  logic [27:0] sv;
  logic [31:0] seed = 32'h0000_05AC;
  sosb_word_t mdl[5] = '{default: 32'h0000_0000};
  int fail_count = 0;
  int n_checks = 0;
  wire logic [18:0] got = {ref32k_clock_o, serial0_clock_o, timer_pwm_clock_o,
    clock_output_pin_o, rtc_output_pin_o, timer_ext_clock_o, timer1_capture_o, timer2_capture_o,
    serial_open_drain_enable_o, serial0_rx_o, serial1_rx_o, serial0_tx_pin_o, serial1_tx_pin_o,
    converter_trigger_o, converter_pretrigger_b_o};
  always #25 clk_i = ~clk_i;
  sosb_peer peer (.src_i(src), .lvl_o(sv));
  sosb_bank #(.ADR_W(13), .IDENT_VALUE(IDV)) dut (.clk_i, .rst_i, .por_lvd_rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .supervisor_i, .sys_osc_32k_clock_i(sv[0]), .rtc_clock_in_pin_i(sv[1]),
    .low_power_osc_i(sv[2]), .fll_output_clock_i(sv[3]), .osc_ext_ref_clock_i(sv[4]),
    .internal_ref_clock_i(sv[5]), .rtc_1hz_i(sv[6]), .timer_clock_in_pin0_i(sv[7]),
    .timer_clock_in_pin1_i(sv[8]), .comparator_zero_i(sv[9]), .timer1_ch0_pin_i(sv[10]),
    .timer2_ch0_pin_i(sv[11]), .serial0_rx_pin_i(sv[12]), .serial1_rx_pin_i(sv[13]),
    .serial0_tx_data_i(sv[14]), .serial1_tx_data_i(sv[15]), .timer1_ch0_out_i(sv[16]),
    .timer2_ch0_out_i(sv[17]), .timer1_ch1_out_i(sv[18]), .external_trigger_pin_i(sv[19]),
    .periodic_trigger0_i(sv[20]), .periodic_trigger1_i(sv[21]), .timer0_overflow_i(sv[22]),
    .timer1_overflow_i(sv[23]), .timer2_overflow_i(sv[24]), .rtc_alarm_i(sv[25]),
    .rtc_seconds_i(sv[26]), .low_power_timer_trigger_i(sv[27]), .ref32k_clock_o,
    .serial0_clock_o, .timer_pwm_clock_o, .clock_output_pin_o, .rtc_output_pin_o,
    .timer_ext_clock_o, .timer1_capture_o, .timer2_capture_o, .serial_open_drain_enable_o,
    .serial0_rx_o, .serial1_rx_o, .serial0_tx_pin_o, .serial1_tx_pin_o, .converter_trigger_o,
    .converter_pretrigger_b_o);
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic tx(input logic [1:0] c, input logic d, input logic [27:0] s);
    return (c == 2'h0) ? d : (c == 2'h1) ? (d & s[16]) : (c == 2'h2) ? (d & s[17]) : 1'b0;
  endfunction : tx
  function automatic logic [18:0] expect_route(input logic [27:0] s);
    logic [31:0] x;
    x = {4'h0, s};
    return {x[R32[mdl[0][19:18]]], x[C4[mdl[1][27:26]]], x[C4[mdl[1][25:24]]],
      x[CO[mdl[1][7:5]]], mdl[1][4] ? s[4] : s[6], mdl[2][26] ? s[8] : s[7],
      mdl[2][25] ? s[8] : s[7], mdl[2][24] ? s[8] : s[7], mdl[2][18] ? s[9] : s[10],
      mdl[2][20] ? s[9] : s[11], mdl[3][18:16], mdl[3][2] ? s[9] : s[12],
      mdl[3][6] ? s[9] : s[13], tx(mdl[3][1:0], s[14], s), tx(mdl[3][5:4], s[15], s),
      mdl[4][7] ? x[TG[mdl[4][3:0]]] : (s[16] | s[18]), mdl[4][7] ? mdl[4][4] : s[18]};
  endfunction : expect_route
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic bus(input logic w, input logic [12:0] a, input sosb_word_t d,
    input logic [3:0] sl, input logic sup, output sosb_word_t q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sl;
    supervisor_i <= sup;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      $display("BAD bus answer exp 1 got 0");
      end_of_test();
    end
  endtask : bus
  task automatic wr(input int i, input sosb_word_t d, input logic [3:0] sl);
    sosb_word_t q;
    logic e;
    bus(1'b1, OFS[i], d, sl, 1'b1, q, e);
    `CHK("write err", 1'b0, e)
    for (int b = 0; b < 4; b++) if (sl[b]) mdl[i][8*b +: 8] = d[8*b +: 8] & MSK[i][8*b +: 8];
  endtask : wr
  task automatic rd(input logic [12:0] a, input sosb_word_t x, input logic ee);
    sosb_word_t q;
    logic e;
    bus(1'b0, a, 32'h0000_0000, 4'hF, 1'b1, q, e);
    `CHK("read err", ee, e)
    if (!ee) `CHK("read data", x, q)
  endtask : rd
  task automatic route_chk();
    logic [18:0] ex;
    logic p;
    repeat (10) @(posedge clk_i);
    ex = expect_route(src);
    // bus clock code: pin must toggle every cycle
    if (mdl[1][7:5] == 3'h2) begin
      p = clock_output_pin_o;
      @(posedge clk_i);
      `CHK("bus clock out", ~p, clock_output_pin_o)
      ex[15] = clock_output_pin_o;
    end
    `CHK("routing", ex, got)
  endtask : route_chk
  initial begin
    sosb_word_t d, q;
    logic e;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    por_lvd_rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) rd(OFS[i], 32'h0000_0000, 1'b0);
    rd(`SOSB_OFF_IDENT, IDV, 1'b0);
    rd(13'h0008, 32'h0000_0000, 1'b1);
    bus(1'b1, `SOSB_OFF_CFG, 32'hFFFF_FFFF, 4'hF, 1'b1, q, e);
    `CHK("cfg write err", 1'b0, e)
    rd(`SOSB_OFF_CFG, 32'h0000_0000, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(i, 32'hFFFF_FF5F, 4'hF);
      rd(OFS[i], mdl[i], 1'b0);
    end
    bus(1'b1, OFS[3], 32'h0000_0000, 4'hF, 1'b0, q, e);
    `CHK("user write err", 1'b1, e)
    rd(OFS[3], mdl[3], 1'b0);
    route_chk();
    wr(0, 32'h0008_0000, 4'hF);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 1; i < 5; i++) mdl[i] = 32'h0000_0000;
    rd(OFS[0], 32'h0008_0000, 1'b0);
    rd(OFS[1], 32'h0000_0000, 1'b0);
    @(posedge clk_i);
    por_lvd_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    por_lvd_rst_i <= 1'b0;
    mdl[0] = 32'h0000_0000;
    rd(OFS[0], 32'h0000_0000, 1'b0);
    for (int k = 0; k < 16; k++) begin
      d = rnd();
      wr(4, {24'h000000, 3'h4, d[0], k[3:0]}, 4'hF);
      src <= d[31:4];
      route_chk();
    end
    for (int it = 0; it < 60; it++) begin
      d = rnd();
      wr(it % 5, d, 4'(rnd()));
      src <= 28'(rnd());
      route_chk();
    end
    wr(2, 32'h0000_0000, 4'hF);
    route_chk();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
